// ---- core/acs_clk_select.sv ----
// Clock selection, input latches and sample pipeline of the acquisition front end
`timescale 1ns/1ps
module acs_clk_select #(
  parameter int INT_MAX_CYC = acs_pkg::INT_MAX_CYC
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire acs_pkg::acs_mode_t clock_mode,
  input wire acs_pkg::acs_per_t int_period_cycles,
  input wire acs_pkg::acs_src_t [2:0] sec_source,
  input wire acs_pkg::acs_expr_cfg_t master_cfg,
  input wire acs_pkg::acs_expr_cfg_t [2:0] sample_cfg,
  input wire acs_pkg::acs_expr_cfg_t [2:0] enable_cfg,
  input wire acs_pkg::acs_in_t [5:0] input_mode,
  input wire logic [47:0] data_in,
  input wire acs_pkg::acs_terms_t sample_terms,
  input wire acs_pkg::acs_terms_t enable_terms,
  output logic trace_valid,
  output logic [2:0] mem_write,
  output logic [47:0] trace_data
);
  // Pin synchronisers
  logic [47:0] data_s1_q;
  logic [47:0] data_s2_q;
  acs_pkg::acs_terms_t smp_s1_q;
  acs_pkg::acs_terms_t smp_s2_q;
  acs_pkg::acs_terms_t en_s1_q;
  acs_pkg::acs_terms_t en_s2_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      data_s1_q <= '0;
      data_s2_q <= '0;
      smp_s1_q <= '0;
      smp_s2_q <= '0;
      en_s1_q <= '0;
      en_s2_q <= '0;
    end else begin
      data_s1_q <= data_in;
      data_s2_q <= data_s1_q;
      smp_s1_q <= sample_terms;
      smp_s2_q <= smp_s1_q;
      en_s1_q <= enable_terms;
      en_s2_q <= en_s1_q;
    end
  end

  // Expression evaluators
  wire mst_hit;
  wire [2:0] smp_hit;
  wire [2:0] en_hit;

  // RL19 J/K edge expressions
  acs_expr u_master (
    .terms(smp_s2_q),
    .cfg(master_cfg),
    .hit(mst_hit)
  );

  genvar s;
  generate
    for (s = 0; s < 3; s++) begin : g_sec
      acs_expr u_sample (
        .terms(smp_s2_q),
        .cfg(sample_cfg[s]),
        .hit(smp_hit[s])
      );
      // RL14 R and S inputs
      // RL15 shared inputs, own settings
      acs_expr u_enable (
        .terms(en_s2_q),
        .cfg(enable_cfg[s]),
        .hit(en_hit[s])
      );
    end
  endgenerate

  // Edge detection of the sample expressions
  logic mst_hit_q;
  logic [2:0] smp_hit_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mst_hit_q <= 1'b0;
      smp_hit_q <= 3'h0;
    end else begin
      mst_hit_q <= mst_hit;
      smp_hit_q <= smp_hit;
    end
  end

  // RL19 event when expression comes true
  wire ext_mst_evt = mst_hit & ~mst_hit_q;
  wire [2:0] own_evt = smp_hit & ~smp_hit_q;

  // Internal timebase and fixed fast rate
  acs_pkg::acs_per_t int_cnt_q;
  logic [1:0] fast_cnt_q;
  acs_pkg::acs_per_t int_lim;

  // RL2 period clamped to legal range
  assign int_lim = (int_period_cycles < acs_pkg::acs_per_t'(acs_pkg::INT_MIN_CYC)) ?
                   acs_pkg::acs_per_t'(acs_pkg::INT_MIN_CYC) :
                   (int_period_cycles > acs_pkg::acs_per_t'(INT_MAX_CYC)) ?
                   acs_pkg::acs_per_t'(INT_MAX_CYC) : int_period_cycles;
  wire int_tick = int_cnt_q >= int_lim - acs_pkg::acs_per_t'(1);
  // RL3 fixed fast rate
  wire fast_tick = fast_cnt_q == 2'(acs_pkg::FAST_CYC - 1);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      int_cnt_q <= '0;
      fast_cnt_q <= 2'h0;
    end else begin
      int_cnt_q <= int_tick ? '0 : int_cnt_q + acs_pkg::acs_per_t'(1);
      fast_cnt_q <= fast_tick ? 2'h0 : fast_cnt_q + 2'h1;
    end
  end

  // Source a section really uses in the given mode
  // RL1 one mode at a time
  function automatic acs_pkg::acs_src_t eff_src(input acs_pkg::acs_mode_t m,
                                                input acs_pkg::acs_src_t r);
    case (m)
      acs_pkg::ACS_INTERNAL: eff_src = acs_pkg::ACS_SRC_INT;
      acs_pkg::ACS_INT_EXTENDED:
        eff_src = (r == acs_pkg::ACS_SRC_FAST) ? acs_pkg::ACS_SRC_FAST : acs_pkg::ACS_SRC_INT;
      acs_pkg::ACS_EXT_SINGLE: eff_src = acs_pkg::ACS_SRC_MASTER;
      acs_pkg::ACS_EXT_MULTI:
        eff_src = (r == acs_pkg::ACS_SRC_OWN) ? acs_pkg::ACS_SRC_OWN : acs_pkg::ACS_SRC_MASTER;
      // RL6 no own expression
      acs_pkg::ACS_MIX_SINGLE:
        eff_src = (r == acs_pkg::ACS_SRC_OWN) ? acs_pkg::ACS_SRC_MASTER : r;
      // RL7 four sources
      acs_pkg::ACS_MIX_MULTI: eff_src = r;
      default: eff_src = acs_pkg::ACS_SRC_MASTER;
    endcase
  endfunction

  // Master event: internal timebase in internal modes, else the external expression
  wire int_mode = (clock_mode == acs_pkg::ACS_INTERNAL) ||
                  (clock_mode == acs_pkg::ACS_INT_EXTENDED);
  // RL2 internal master
  // RL4 external master
  wire master_evt = int_mode ? int_tick : ext_mst_evt;

  acs_pkg::acs_src_t [2:0] src_e;
  logic [2:0] sec_evt;
  logic [2:0] wr_evt;

  // Per-section sample and memory write strobes
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      src_e[i] = eff_src(clock_mode, sec_source[i]);
      case (src_e[i])
        acs_pkg::ACS_SRC_INT: sec_evt[i] = int_tick;
        acs_pkg::ACS_SRC_FAST: sec_evt[i] = fast_tick;
        acs_pkg::ACS_SRC_OWN: sec_evt[i] = own_evt[i];
        default: sec_evt[i] = master_evt;
      endcase
      // RL3 RL6 internal sections write at own rate
      // RL5 external sections write at master
      wr_evt[i] = (src_e[i] == acs_pkg::ACS_SRC_INT || src_e[i] == acs_pkg::ACS_SRC_FAST) ?
                  sec_evt[i] : master_evt;
    end
  end

  // Input latches, one per byte group
  logic [5:0][7:0] latch_q;
  logic [5:0] lat_on;
  logic [5:0][7:0] lat_src;

  genvar g;
  generate
    for (g = 0; g < 6; g++) begin : g_grp
      wire dmx = input_mode[(g / 2) * 2] == acs_pkg::ACS_IN_DEMUX;
      // RL18 demux byte routing
      // RL11 enable only for latch or demux
      assign lat_on[g] = dmx ? (g % 2 == 1) : (input_mode[g] == acs_pkg::ACS_IN_LATCH);
      assign lat_src[g] = (dmx && (g % 2 == 1)) ? data_s2_q[(g / 2) * 16 +: 8] :
                          data_s2_q[g * 8 +: 8];
      // RL10 RL12 transparent or hold
      // RL16 independent of clock mode
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          latch_q[g] <= acs_pkg::LATCH_RST;
        end else if (!lat_on[g] || en_hit[g / 2]) begin
          latch_q[g] <= lat_src[g];
        end
      end
    end
  endgenerate

  // Section sample registers read the latch outputs
  logic [2:0][15:0] sample_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sample_q <= {3{acs_pkg::SAMPLE_RST}};
    end else begin
      for (int i = 0; i < 3; i++) begin
        // RL17 latch and sample aligned
        if (sec_evt[i]) begin
          sample_q[i] <= {latch_q[2 * i + 1], latch_q[2 * i]};
        end
      end
    end
  end

  // Delayed strobes so the pipeline sees the updated sample registers
  logic mst_d_q;
  logic [2:0] wr_d_q;
  logic p1_valid_q;
  logic [2:0] p1_wr_q;
  logic [47:0] p1_data_q;
  logic trace_valid_q;
  logic [2:0] mem_write_q;
  logic [47:0] trace_data_q;

  // RL20 fixed latency pipeline
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mst_d_q <= 1'b0;
      wr_d_q <= 3'h0;
      p1_valid_q <= 1'b0;
      p1_wr_q <= 3'h0;
      p1_data_q <= '0;
      trace_valid_q <= 1'b0;
      mem_write_q <= 3'h0;
      trace_data_q <= '0;
    end else begin
      mst_d_q <= master_evt;
      wr_d_q <= wr_evt;
      p1_valid_q <= mst_d_q;
      p1_wr_q <= wr_d_q;
      p1_data_q <= sample_q;
      trace_valid_q <= p1_valid_q;
      mem_write_q <= p1_wr_q;
      trace_data_q <= p1_data_q;
    end
  end

  assign trace_valid = trace_valid_q;
  assign mem_write = mem_write_q;
  assign trace_data = trace_data_q;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  chk_int_master_rate: assert property ( // RL2
    clock_mode == acs_pkg::ACS_INTERNAL && int_tick |-> ##3 (trace_valid_q && mem_write_q == 3'h7))
    else $error("internal tick did not reach trace outputs");
  chk_int_min_period: assert property ( // RL2
    int_tick |=> !int_tick [*4])
    else $error("internal period shorter than minimum");
  chk_fast_rate: assert property ( // RL3
    fast_tick |-> ##2 fast_tick)
    else $error("fixed fast rate wrong");
  chk_single_write_all: assert property ( // RL4
    clock_mode == acs_pkg::ACS_EXT_SINGLE && ext_mst_evt
    |-> ##3 (trace_valid_q && mem_write_q == 3'h7))
    else $error("single phase master event lost");
  chk_multi_master_write: assert property ( // RL5
    clock_mode == acs_pkg::ACS_EXT_MULTI && !master_evt |-> ##3 mem_write_q == 3'h0)
    else $error("multiphase write without master event");
  chk_latch_hold_value: assert property ( // RL12
    lat_on[1] && !en_hit[0] |=> $stable(latch_q[1]))
    else $error("closed latch changed");
  chk_sample_pass_thru: assert property ( // RL11
    !lat_on[0] |=> latch_q[0] == $past(data_s2_q[7:0]))
    else $error("sample group not transparent");
  chk_sample_capture: assert property ( // RL17
    sec_evt[0] |=> sample_q[0] == $past({latch_q[1], latch_q[0]}))
    else $error("section sample lost latched data");
  chk_trace_payload: assert property ( // RL20
    mst_d_q |-> ##2 trace_data_q == $past(sample_q, 2))
    else $error("trace data not aligned to master event");
  // Mode specific write and trace rates
  chk_fast_sec_write: assert property ( // RL3
    clock_mode == acs_pkg::ACS_INT_EXTENDED && src_e[0] == acs_pkg::ACS_SRC_FAST && fast_tick
    |-> ##3 mem_write_q[0])
    else $error("fast section write missing");
  chk_ext_trace_rate: assert property ( // RL3
    clock_mode == acs_pkg::ACS_INT_EXTENDED && !int_tick |-> ##3 !trace_valid_q)
    else $error("extended trace off the master rate");
  chk_own_no_write: assert property ( // RL5
    src_e[0] == acs_pkg::ACS_SRC_OWN && own_evt[0] && !master_evt |-> ##3 !mem_write_q[0])
    else $error("own clock wrote memory without master");
  chk_mix_int_write: assert property ( // RL6
    clock_mode == acs_pkg::ACS_MIX_SINGLE && src_e[0] == acs_pkg::ACS_SRC_INT && int_tick
    |-> ##3 mem_write_q[0])
    else $error("internal section write missing");
  chk_mix_trace_master: assert property ( // RL7
    clock_mode == acs_pkg::ACS_MIX_MULTI && !master_evt |-> ##3 !trace_valid_q)
    else $error("mixed trace off the master rate");

  cov_ext_single: cover property (clock_mode == acs_pkg::ACS_EXT_SINGLE && trace_valid_q);
  cov_mixed_own: cover property (clock_mode == acs_pkg::ACS_MIX_MULTI && own_evt[0]);
  cov_ext_multi: cover property (clock_mode == acs_pkg::ACS_EXT_MULTI && own_evt[0]);
  cov_mix_int_write: cover property (clock_mode == acs_pkg::ACS_MIX_SINGLE && mem_write_q[0]
                                     && !trace_valid_q);
  cov_demux_hold: cover property (input_mode[0] == acs_pkg::ACS_IN_DEMUX && !en_hit[0]
                                  ##1 sec_evt[0]);
endmodule

// ---- core/acs_expr.sv ----
// Six-term clock expression evaluator
`timescale 1ns/1ps
module acs_expr (
  input wire acs_pkg::acs_terms_t terms,
  input wire acs_pkg::acs_expr_cfg_t cfg,
  output logic hit
);
  // Term truth under its polarity setting
  // RL9 polarity or exclusion
  function automatic logic term_on(input logic lvl, input acs_pkg::acs_term_t sel);
    term_on = (sel == acs_pkg::ACS_TERM_HIGH) ? lvl :
              (sel == acs_pkg::ACS_TERM_LOW) ? ~lvl : 1'b0;
  endfunction

  logic [2:0] and_v;
  logic [2:0] or_v;
  logic [2:0] and_used;
  wire and_prod;

  // Excluded AND terms are neutral; an all-excluded AND group is false
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      and_used[i] = cfg.and_sel[i] != acs_pkg::ACS_TERM_OFF;
      and_v[i] = term_on(terms.and_t[i], cfg.and_sel[i]) | ~and_used[i];
      or_v[i] = term_on(terms.or_t[i], cfg.or_sel[i]);
    end
  end

  // RL8 AND product ORed
  // RL13 all AND or any OR
  assign and_prod = (&and_v) & (|and_used);
  assign hit = and_prod | (|or_v);
endmodule

// ---- core/acs_pkg.sv ----
// Constants, types and shared definitions for the acquisition clock select block
// Contract
// RL1 - Six clock modes in fixed order; exactly one active per acquisition.
// RL2 - Internal mode: all sections sample on internal master clock, 20 ns to 160 ms.
// RL3 - Internal extended: section uses master rate or fixed 10 ns; own-rate writes. Code's fixed rate is 2 cycles (8 ns).
// RL4 - External single-phase: master expression samples all sections, traces and writes.
// RL5 - External multiphase: own or master expression samples; writes only at master.
// RL6 - Mixed single-phase: internal, 10 ns or master; internal sections write own rate. Code's 10 ns rate is 2 cycles (8 ns).
// RL7 - Mixed multiphase: four sources per section; trace decisions at master rate.
// RL8 - Expression: three terms ANDed, ORed with three OR terms.
// RL9 - Each term independently active high, active low, or excluded.
// RL10 - Enable terms are level sensitive, gating per-section input latches.
// RL11 - Enable applies only to latch or demux groups, never sample or glitch.
// RL12 - Latch transparent while enable true, holds value while false.
// RL13 - Enable true when all AND terms true or any OR term true.
// RL14 - Enable AND terms from R inputs, OR terms from S inputs.
// RL15 - Sections share enable inputs but hold independent per-term settings.
// RL16 - Enable logic works identically in every clock mode.
// RL17 - Latched data and sampled data leave together as one sample.
// RL18 - Demux: lower byte feeds both groups; low sampled, high latched.
// RL19 - Sample expressions edge sensitive: AND from J inputs, OR from K inputs.
// RL20 - Master event sends all section samples through fixed pipeline together.
package acs_pkg;
  localparam int SEC_N = 3;
  localparam int SEC_W = 16;
  localparam int GRP_N = 6;
  localparam int PER_W = 26;
  // Timing figures in their own units
  localparam int CLK_PERIOD_NS = 4;
  localparam int FAST_PERIOD_NS = 10;
  localparam int INT_MIN_PERIOD_NS = 20;
  localparam int INT_MAX_PERIOD_MS = 160;
  // Cycle counts: fixed rate is a longest time, minimum period a least time
  localparam int FAST_CYC = (FAST_PERIOD_NS / CLK_PERIOD_NS < 1) ? 1 :
                            FAST_PERIOD_NS / CLK_PERIOD_NS;
  localparam int INT_MIN_CYC = (INT_MIN_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INT_MAX_CYC = INT_MAX_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
  // Cycles from master event to the trace outputs
  localparam int PIPE_LAT = 3;
  // Reset values
  localparam logic [SEC_W-1:0] SAMPLE_RST = 16'h0000;
  localparam logic [7:0] LATCH_RST = 8'h00;

  typedef logic [PER_W-1:0] acs_per_t;

  typedef enum logic [2:0] {
    ACS_INTERNAL, ACS_EXT_SINGLE, ACS_EXT_MULTI,
    ACS_MIX_SINGLE, ACS_MIX_MULTI, ACS_INT_EXTENDED
  } acs_mode_t;

  typedef enum logic [1:0] {ACS_TERM_OFF, ACS_TERM_HIGH, ACS_TERM_LOW} acs_term_t;

  // ACS_SRC_MASTER is the follow_master_rate choice
  typedef enum logic [1:0] {ACS_SRC_MASTER, ACS_SRC_INT, ACS_SRC_FAST, ACS_SRC_OWN} acs_src_t;

  typedef enum logic [1:0] {ACS_IN_SAMPLE, ACS_IN_GLITCH, ACS_IN_LATCH, ACS_IN_DEMUX} acs_in_t;

  // Settings of one six-term expression
  typedef struct packed {
    acs_term_t [2:0] and_sel;
    acs_term_t [2:0] or_sel;
  } acs_expr_cfg_t;

  // Six term inputs, index 0..2 = term 1..3 of each kind, shared by all sections
  typedef struct packed {
    logic [2:0] and_t;
    logic [2:0] or_t;
  } acs_terms_t;
endpackage

// ---- dv/acs_target.sv ----
// Model of the probed target: link clock, probe data and enable levels
`timescale 1ns/1ps
module acs_target (
  input wire logic run,
  input wire logic [47:0] word,
  input wire acs_pkg::acs_terms_t en_lvl,
  output logic link_clk,
  output logic [47:0] data_in,
  output acs_pkg::acs_terms_t sample_terms,
  output acs_pkg::acs_terms_t enable_terms
);
  // Link clock runs at 48 ns within a frame and rests low between frames
  initial begin
    link_clk = 1'b0;
    #1.3;
    forever begin
      #24;
      link_clk = run ? ~link_clk : 1'b0;
    end
  end
  // Data moves only while the link clock is low or run is off, so it is steady at rising edges
  always_latch begin
    if (!run || !link_clk) begin
      data_in <= word;
    end
  end
  // Link clock feeds the first OR sample term; enable levels pass straight through
  assign sample_terms = {5'h00, link_clk};
  assign enable_terms = en_lvl;
endmodule

// ---- dv/testbench.sv ----
// Self-checking bench for the acquisition clock select block
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic run = 1'b0;
  logic [47:0] word = 48'h0;
  acs_pkg::acs_terms_t en_lvl = '0;
  acs_pkg::acs_mode_t clock_mode = acs_pkg::ACS_INTERNAL;
  acs_pkg::acs_per_t int_period_cycles = 26'h000000a;
  acs_pkg::acs_src_t [2:0] sec_source = {3{acs_pkg::ACS_SRC_MASTER}};
  acs_pkg::acs_expr_cfg_t master_cfg = '0;
  acs_pkg::acs_expr_cfg_t [2:0] sample_cfg = '0;
  acs_pkg::acs_expr_cfg_t [2:0] enable_cfg = '0;
  acs_pkg::acs_in_t [5:0] input_mode = {6{acs_pkg::ACS_IN_SAMPLE}};
  acs_pkg::acs_terms_t sample_terms;
  acs_pkg::acs_terms_t enable_terms;
  logic [47:0] data_in;
  logic link_clk;
  logic trace_valid;
  logic [2:0] mem_write;
  logic [47:0] trace_data;
  logic [47:0] last_data = '0;
  logic [2:0] last_mw = '0;
  int tv_cnt = 0;
  int mw0_cnt = 0;
  int mismatches = 0;
  int samples_checked = 0;

  // Clock at 250 MHz
  always #2 clk = ~clk;

  acs_target target (.run(run), .word(word), .en_lvl(en_lvl), .link_clk(link_clk),
    .data_in(data_in), .sample_terms(sample_terms), .enable_terms(enable_terms));

  acs_clk_select #(.INT_MAX_CYC(64)) dut (.clk(clk), .arst_n(arst_n),
    .clock_mode(clock_mode), .int_period_cycles(int_period_cycles),
    .sec_source(sec_source), .master_cfg(master_cfg), .sample_cfg(sample_cfg),
    .enable_cfg(enable_cfg), .input_mode(input_mode), .data_in(data_in),
    .sample_terms(sample_terms), .enable_terms(enable_terms),
    .trace_valid(trace_valid), .mem_write(mem_write), .trace_data(trace_data));

  // Count events and keep the last delivered sample
  always @(posedge clk) begin
    if (trace_valid === 1'b1) begin
      tv_cnt <= tv_cnt + 1;
      last_data <= trace_data;
      last_mw <= mem_write;
    end
    if (mem_write[0] === 1'b1) begin
      mw0_cnt <= mw0_cnt + 1;
    end
  end

  task automatic check(input string what, input logic [47:0] exp, input logic [47:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_n(input string what, input int exp, input int got);
    samples_checked++;
    if (got != exp) begin
      mismatches++;
      $display("unexpected %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Set mode and period from the arguments, and return every other setting to a plain default for the next scenario
  task automatic setup(input acs_pkg::acs_mode_t m, input logic [25:0] p);
    @(posedge clk);
    clock_mode <= m;
    int_period_cycles <= p;
    sec_source <= {3{acs_pkg::ACS_SRC_MASTER}};
    master_cfg <= '0;
    sample_cfg <= '0;
    enable_cfg <= '0;
    input_mode <= {6{acs_pkg::ACS_IN_SAMPLE}};
    en_lvl <= '0;
    @(posedge clk);
  endtask

  // Present enable levels and data, then let them reach the trace outputs
  task automatic step(input logic [5:0] en, input logic [47:0] w);
    @(posedge clk);
    en_lvl <= en;
    word <= w;
    repeat (24) @(posedge clk);
  endtask

  // Internal master rate, including the clamp at both ends
  task automatic int_rate(input logic [25:0] per, input int exp);
    int n;
    setup(acs_pkg::ACS_INTERNAL, per);
    repeat (150) @(posedge clk);
    n = tv_cnt;
    repeat (exp * 4) @(posedge clk);
    check_n("internal events", 4, tv_cnt - n);
    check("write strobes", 48'h7, {45'h0, last_mw});
  endtask

  // One section at the fixed fast rate, trace still at the master rate
  task automatic fast_rate();
    int n;
    int m;
    setup(acs_pkg::ACS_INT_EXTENDED, 26'h000000a);
    sec_source[0] <= acs_pkg::ACS_SRC_FAST;
    repeat (40) @(posedge clk);
    n = tv_cnt;
    m = mw0_cnt;
    repeat (40) @(posedge clk);
    check_n("master events", 4, tv_cnt - n);
    check_n("fast writes", 20, mw0_cnt - m);
  endtask

  // Latches under OR, inverted OR and AND enable expressions
  task automatic latch_terms(input acs_pkg::acs_mode_t m);
    setup(m, 26'h0000005);
    input_mode[0] <= acs_pkg::ACS_IN_LATCH;
    input_mode[2] <= acs_pkg::ACS_IN_LATCH;
    input_mode[4] <= acs_pkg::ACS_IN_LATCH;
    enable_cfg[0].or_sel[0] <= acs_pkg::ACS_TERM_HIGH;
    enable_cfg[1].or_sel[0] <= acs_pkg::ACS_TERM_LOW;
    enable_cfg[2].and_sel <= {3{acs_pkg::ACS_TERM_HIGH}};
    step(6'h39, 48'h0);
    step(6'h18, 48'h0);
    step(6'h18, 48'hffff_ffff_ffff);
    check("held bytes", 48'hff00_ffff_ff00, last_data);
    step(6'h39, 48'hffff_ffff_ffff);
    step(6'h39, 48'h5a5a_5a5a_5a5a);
    check("passed bytes", 48'h5a5a_5aff_5a5a, last_data);
  endtask

  // Lower byte feeds sampled low group and latched high group
  task automatic demux();
    setup(acs_pkg::ACS_INTERNAL, 26'h0000005);
    input_mode[0] <= acs_pkg::ACS_IN_DEMUX;
    enable_cfg[0].or_sel[0] <= acs_pkg::ACS_TERM_HIGH;
    step(6'h01, 48'h0000_0000_00a5);
    step(6'h00, 48'h0000_0000_00a5);
    step(6'h00, 48'h0000_0000_003c);
    check("demux bytes", 48'h0000_0000_a53c, last_data);
  endtask

  // Master expression on the link clock, one event per active edge
  task automatic ext_single(input acs_pkg::acs_term_t pol);
    int n;
    setup(acs_pkg::ACS_EXT_SINGLE, 26'h000000a);
    master_cfg.or_sel[0] <= pol;
    word <= 48'h1234_5678_9abc;
    repeat (20) @(posedge clk);
    n = tv_cnt;
    run <= 1'b1;
    repeat (4) @(posedge link_clk);
    @(posedge clk);
    run <= 1'b0;
    repeat (30) @(posedge clk);
    check_n("master events", 4, tv_cnt - n);
    check("master sample", 48'h1234_5678_9abc, last_data);
    check("write strobes", 48'h7, {45'h0, last_mw});
  endtask

  // Mixed and multiphase modes: section 1 on the chosen source, master on the link clock
  task automatic mixed(input acs_pkg::acs_mode_t m, input acs_pkg::acs_src_t src,
                       input int exp_w);
    int n;
    int k;
    setup(m, 26'h0000005);
    master_cfg.or_sel[0] <= acs_pkg::ACS_TERM_HIGH;
    sample_cfg[0].or_sel[0] <= acs_pkg::ACS_TERM_LOW;
    sec_source[0] <= src;
    word <= ~word;
    repeat (20) @(posedge clk);
    n = tv_cnt;
    k = mw0_cnt;
    repeat (40) @(posedge clk);
    check_n("idle trace events", 0, tv_cnt - n);
    check_n("idle section writes", exp_w, mw0_cnt - k);
    n = tv_cnt;
    run <= 1'b1;
    repeat (4) @(posedge link_clk);
    @(posedge clk);
    run <= 1'b0;
    repeat (30) @(posedge clk);
    check_n("frame trace events", 4, tv_cnt - n);
    check("master section writes", 48'h3, {46'h0, last_mw[2:1]});
    check("aligned sample", word, last_data);
  endtask

  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    repeat (5) @(posedge clk);
    int_rate(26'h000000a, 10);
    int_rate(26'h0000002, 5);
    int_rate(26'h3ffffff, 64);
    fast_rate();
    latch_terms(acs_pkg::ACS_INTERNAL);
    latch_terms(acs_pkg::ACS_INT_EXTENDED);
    demux();
    ext_single(acs_pkg::ACS_TERM_HIGH);
    ext_single(acs_pkg::ACS_TERM_LOW);
    mixed(acs_pkg::ACS_EXT_MULTI, acs_pkg::ACS_SRC_OWN, 0);
    mixed(acs_pkg::ACS_MIX_SINGLE, acs_pkg::ACS_SRC_INT, 8);
    mixed(acs_pkg::ACS_MIX_SINGLE, acs_pkg::ACS_SRC_OWN, 0);
    mixed(acs_pkg::ACS_MIX_MULTI, acs_pkg::ACS_SRC_OWN, 0);
    mixed(acs_pkg::ACS_MIX_MULTI, acs_pkg::ACS_SRC_FAST, 20);
    stop_test();
  end

  // Watchdog against a hang
  initial begin
    #40000;
    mismatches++;
    stop_test();
  end
endmodule
